// ### hdl/ieb_axil.sv
/*
  axi4-lite slave front end: accepts one write and one read at a time,
  turns them into a register write strobe and a read index.
  assumes a single clock and a master that holds valid until ready.
*/
`timescale 1ns/1ps
`default_nettype none
module ieb_axil
  import ieb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [IEB_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IEB_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output ieb_wr_s wr,
  output logic [IEB_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_reg, aw_next;
  logic w_reg, w_next;
  logic [IEB_AW-1:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic bv_reg, bv_next;
  logic [1:0] br_reg, br_next;
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic wr_ok;

  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready = !w_reg && !bv_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign rd_addr = s_axi_araddr;
  assign wr_ok = (awa_reg == IEB_OFS_ENABLE);

  // write strobe fires once both address and data are held and the address is the enable register
  always_comb begin
    wr.en = aw_reg && w_reg && !bv_reg && wr_ok;
    wr.data = wd_reg[15:0];
    wr.strb = ws_reg[1:0];
  end

  // next state of both channels
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (aw_reg && w_reg && !bv_reg) begin
      bv_next = 1'b1;
      br_next = wr_ok ? IEB_RESP_OKAY : IEB_RESP_SLVERR;
      aw_next = 1'b0;
      w_next = 1'b0;
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rd_next = rd_ok ? rd_data : 32'h0000_0000;
      rr_next = rd_ok ? IEB_RESP_OKAY : IEB_RESP_SLVERR;
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  // channel registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awa_reg <= '0;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      bv_reg <= 1'b0;
      br_reg <= IEB_RESP_OKAY;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rr_reg <= IEB_RESP_OKAY;
    end else begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end
endmodule
`default_nettype wire

// ### hdl/ieb_gate.sv
/*
  gate cell: passes one source request when its enable bit is set.
  assumes request levels synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ieb_gate (
  input wire logic req,
  input wire logic enable,
  output logic gated
);
  // and-gate the request with its enable
  assign gated = req & enable;
endmodule
`default_nettype wire

// ### hdl/ieb_pkg.sv
/*
  package for the interrupt enable bank: register map, bit positions,
  reset values and the packed carriers shared by the design files.
  assumes a 32-bit axi4-lite register bus and 16 peripheral sources.
*/
package ieb_pkg;

  localparam int IEB_NSRC = 16;
  localparam int IEB_AW = 4;

  // byte offsets on the register bus
  localparam logic [IEB_AW-1:0] IEB_OFS_ENABLE = 4'h0;
  localparam logic [IEB_AW-1:0] IEB_OFS_PENDING = 4'h4;

  // enable bit positions
  localparam int IEB_BIT_UART2_TX = 15;
  localparam int IEB_BIT_UART2_RX = 14;
  localparam int IEB_BIT_EXT2 = 13;
  localparam int IEB_BIT_TMR5 = 12;
  localparam int IEB_BIT_TMR4 = 11;
  localparam int IEB_BIT_OC4 = 10;
  localparam int IEB_BIT_OC3 = 9;
  localparam int IEB_BIT_DMA2 = 8;
  localparam int IEB_BIT_IC8 = 7;
  localparam int IEB_BIT_IC7 = 6;
  localparam int IEB_BIT_ADC2 = 5;
  localparam int IEB_BIT_EXT1 = 4;
  localparam int IEB_BIT_CHG = 3;
  localparam int IEB_BIT_UNUSED = 2;
  localparam int IEB_BIT_I2C1_M = 1;
  localparam int IEB_BIT_I2C1_S = 0;

  // implemented-bit mask and reset value
  localparam logic [15:0] IEB_IMPL_MASK = 16'hfffb;
  localparam logic [15:0] IEB_RESET_VAL = 16'h0000;

  // axi response codes
  localparam logic [1:0] IEB_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEB_RESP_SLVERR = 2'h2;

  // one register write as seen by the bank
  typedef struct packed {
    logic        en;
    logic [15:0] data;
    logic [1:0]  strb;
  } ieb_wr_s;

endpackage

// ### hdl/ieb_top.sv
/*
  interrupt enable bank one: a 16-bit enable register that gates the
  requests of sixteen peripheral sources on their way to the priority
  logic, plus a read-only view of the raw requests.
  assumes source requests are levels synchronous to clk and that the
  priority logic samples the gated vector each cycle.
*/
// Summary of operation
// - enable one passes request, zero blocks it
// - bit 14 gates uart two receive
// - bit 13 gates external pin two
// - bits 12 and 11 gate timers five, four
// - bit 10 gates output compare four
// - bit 9 gates output compare three
// - bit 8 gates dma channel two done
// - bit 7 gates input capture eight
// - bit 6 gates input capture seven
// - bit 5 gates adc two done
// - bit 3 gates change notification
// - bit 2 reads zero, ignores writes
// - bit 1 gates i2c one master
// - bit 0 gates i2c one slave
`timescale 1ns/1ps
`default_nettype none
module ieb_top
  import ieb_pkg::*;
#(
  parameter int NSRC = IEB_NSRC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [IEB_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IEB_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0] src_req,
  output logic [NSRC-1:0] gated_req
);
  ieb_wr_s wr;
  logic [IEB_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [15:0] interrupt_enable_control_one_reg;
  logic [15:0] interrupt_enable_control_one_next;
  logic [NSRC-1:0] gated_comb;
  logic [NSRC-1:0] gated_reg;

  // named views of the enable fields
  logic uart_two_tx_irq_enable;
  logic uart_two_rx_irq_enable;
  logic ext_pin_two_irq_enable;
  logic timer_five_irq_enable;
  logic timer_four_irq_enable;
  logic out_compare_four_irq_enable;
  logic out_compare_three_irq_enable;
  logic dma_chan_two_done_irq_enable;
  logic in_capture_eight_irq_enable;
  logic in_capture_seven_irq_enable;
  logic adc_two_done_irq_enable;
  logic ext_pin_one_irq_enable;
  logic change_notify_irq_enable;
  logic i2c_one_master_irq_enable;
  logic i2c_one_slave_irq_enable;

  assign uart_two_tx_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_UART2_TX];
  assign uart_two_rx_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_UART2_RX];
  assign ext_pin_two_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_EXT2];
  assign timer_five_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_TMR5];
  assign timer_four_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_TMR4];
  assign out_compare_four_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_OC4];
  assign out_compare_three_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_OC3];
  assign dma_chan_two_done_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_DMA2];
  assign in_capture_eight_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_IC8];
  assign in_capture_seven_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_IC7];
  assign adc_two_done_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_ADC2];
  assign ext_pin_one_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_EXT1];
  assign change_notify_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_CHG];
  assign i2c_one_master_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_I2C1_M];
  assign i2c_one_slave_irq_enable =
    interrupt_enable_control_one_reg[IEB_BIT_I2C1_S];

  // bus front end
  ieb_axil u_axil (
    .clk(clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // byte-lane write, unimplemented bit forced to zero
  always_comb begin
    interrupt_enable_control_one_next = interrupt_enable_control_one_reg;
    if (wr.en) begin
      if (wr.strb[0]) begin
        interrupt_enable_control_one_next[7:0] = wr.data[7:0];
      end
      if (wr.strb[1]) begin
        interrupt_enable_control_one_next[15:8] = wr.data[15:8];
      end
    end
    interrupt_enable_control_one_next =
      interrupt_enable_control_one_next & IEB_IMPL_MASK;
  end

  // enable register, masked after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_enable_control_one_reg <= IEB_RESET_VAL;
    end else begin
      interrupt_enable_control_one_reg <= interrupt_enable_control_one_next;
    end
  end

  // read mux: enable register and raw request view
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (rd_addr)
      IEB_OFS_ENABLE: rd_data[15:0] = interrupt_enable_control_one_reg;
      IEB_OFS_PENDING: rd_data[NSRC-1:0] = src_req;
      default: rd_ok = 1'b0;
    endcase
  end

  // one gate cell per source
  for (genvar i = 0; i < NSRC; i++) begin : g_gate
    ieb_gate u_gate (
      .req(src_req[i]),
      .enable(interrupt_enable_control_one_reg[i]),
      .gated(gated_comb[i])
    );
  end

  // registered gated vector toward priority logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gated_reg <= '0;
    end else begin
      gated_reg <= gated_comb;
    end
  end
  assign gated_req = gated_reg;

  // gated output follows request and enable one cycle later
  gate_follow_a: assert property (@(posedge clk)
    disable iff (!resetn)
    ##1 gated_req == $past(src_req & interrupt_enable_control_one_reg))
    else $error("gated request mismatch");
  uart_rx_gate_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !uart_two_rx_irq_enable |=> !gated_req[IEB_BIT_UART2_RX])
    else $error("uart rx not blocked");
  ext_two_gate_a: assert property (@(posedge clk)
    disable iff (!resetn)
    ext_pin_two_irq_enable && src_req[IEB_BIT_EXT2]
    |=> gated_req[IEB_BIT_EXT2])
    else $error("pin two not passed");
  timer_gate_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !timer_five_irq_enable && !timer_four_irq_enable
    |=> !gated_req[IEB_BIT_TMR5] && !gated_req[IEB_BIT_TMR4])
    else $error("timer request leaked");
  oc4_gate_a: assert property (@(posedge clk)
    disable iff (!resetn)
    out_compare_four_irq_enable && src_req[IEB_BIT_OC4]
    |=> gated_req[IEB_BIT_OC4])
    else $error("oc four not passed");
  dma_gate_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !dma_chan_two_done_irq_enable |=> !gated_req[IEB_BIT_DMA2])
    else $error("dma request leaked");
  unused_bit_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !interrupt_enable_control_one_reg[IEB_BIT_UNUSED]
    && !gated_req[IEB_BIT_UNUSED])
    else $error("unimplemented bit set");
  write_lands_a: assert property (@(posedge clk)
    disable iff (!resetn)
    wr.en && (&wr.strb)
    |=> interrupt_enable_control_one_reg == ($past(wr.data) & IEB_IMPL_MASK))
    else $error("enable write lost");
  reset_clear_a: assert property (@(posedge clk)
    $rose(resetn) |-> interrupt_enable_control_one_reg == IEB_RESET_VAL)
    else $error("enables not cleared");

  // a clear enable keeps its source away from the priority logic
  uart_tx_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !uart_two_tx_irq_enable |=> !gated_req[IEB_BIT_UART2_TX])
    else $error("uart tx not blocked");
  ext_one_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !ext_pin_one_irq_enable |=> !gated_req[IEB_BIT_EXT1])
    else $error("pin one not blocked");
  oc3_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !out_compare_three_irq_enable |=> !gated_req[IEB_BIT_OC3])
    else $error("oc three not blocked");
  ic8_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !in_capture_eight_irq_enable |=> !gated_req[IEB_BIT_IC8])
    else $error("capture eight not blocked");
  ic7_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !in_capture_seven_irq_enable |=> !gated_req[IEB_BIT_IC7])
    else $error("capture seven not blocked");
  adc_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !adc_two_done_irq_enable |=> !gated_req[IEB_BIT_ADC2])
    else $error("adc two not blocked");
  chg_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !change_notify_irq_enable |=> !gated_req[IEB_BIT_CHG])
    else $error("change notify not blocked");
  i2c_master_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !i2c_one_master_irq_enable |=> !gated_req[IEB_BIT_I2C1_M])
    else $error("i2c master not blocked");
  i2c_slave_block_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !i2c_one_slave_irq_enable |=> !gated_req[IEB_BIT_I2C1_S])
    else $error("i2c slave not blocked");

  // a set enable lets a raised request through on the next edge
  uart_tx_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    uart_two_tx_irq_enable && src_req[IEB_BIT_UART2_TX]
    |=> gated_req[IEB_BIT_UART2_TX])
    else $error("uart tx not passed");
  ext_one_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    ext_pin_one_irq_enable && src_req[IEB_BIT_EXT1]
    |=> gated_req[IEB_BIT_EXT1])
    else $error("pin one not passed");
  uart_rx_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    uart_two_rx_irq_enable && src_req[IEB_BIT_UART2_RX]
    |=> gated_req[IEB_BIT_UART2_RX])
    else $error("uart rx not passed");
  oc3_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    out_compare_three_irq_enable && src_req[IEB_BIT_OC3]
    |=> gated_req[IEB_BIT_OC3])
    else $error("oc three not passed");
  ic8_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    in_capture_eight_irq_enable && src_req[IEB_BIT_IC8]
    |=> gated_req[IEB_BIT_IC8])
    else $error("capture eight not passed");
  ic7_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    in_capture_seven_irq_enable && src_req[IEB_BIT_IC7]
    |=> gated_req[IEB_BIT_IC7])
    else $error("capture seven not passed");
  adc_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    adc_two_done_irq_enable && src_req[IEB_BIT_ADC2]
    |=> gated_req[IEB_BIT_ADC2])
    else $error("adc two not passed");
  chg_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    change_notify_irq_enable && src_req[IEB_BIT_CHG]
    |=> gated_req[IEB_BIT_CHG])
    else $error("change notify not passed");
  i2c_master_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    i2c_one_master_irq_enable && src_req[IEB_BIT_I2C1_M]
    |=> gated_req[IEB_BIT_I2C1_M])
    else $error("i2c master not passed");
  i2c_slave_pass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    i2c_one_slave_irq_enable && src_req[IEB_BIT_I2C1_S]
    |=> gated_req[IEB_BIT_I2C1_S])
    else $error("i2c slave not passed");
endmodule
`default_nettype wire

// ### verif/ieb_top_test.sv
/*
  self-checking bench for the interrupt enable bank: register traffic
  over axi4-lite, per-source gating, reset and unmapped accesses.
  assumes the bank top and its package from hdl/, one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ieb_top_test
  import ieb_pkg::*;
;
  logic clk;
  logic resetn;
  logic [IEB_AW-1:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [IEB_AW-1:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [15:0] src_req;
  logic [15:0] gated_req;
  int err_total = 0;
  int checks = 0;

  ieb_top #(.NSRC(16)) ieb_top_inst (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_req(src_req),
    .gated_req(gated_req)
  );

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog well beyond the expected run
  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // expected enable value after a strobed write
  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    return ((old & ~m) | (d & m)) & ~(16'h1 << IEB_BIT_UNUSED);
  endfunction

  // one write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        break;
      end
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  // one read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit ar_ok;
    ar_ok = 1'b0;
    d = '1;
    r = 2'h3;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar_ok && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  // drive requests, compare the gated vector two clock edges later
  task automatic gate_chk(input logic [15:0] v, input logic [15:0] en);
    src_req <= v;
    repeat (2) @(posedge clk);
    chk(32'(gated_req), 32'(v & en), "gated request");
  endtask

  // main sequence
  initial begin
    logic [15:0] model;
    logic [15:0] impl;
    logic [15:0] v;
    logic [15:0] b;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [3:0] st;
    int bits[15];
    bits = '{IEB_BIT_UART2_TX, IEB_BIT_UART2_RX, IEB_BIT_EXT2,
             IEB_BIT_TMR5, IEB_BIT_TMR4, IEB_BIT_OC4, IEB_BIT_OC3,
             IEB_BIT_DMA2, IEB_BIT_IC8, IEB_BIT_IC7, IEB_BIT_ADC2,
             IEB_BIT_EXT1, IEB_BIT_CHG, IEB_BIT_I2C1_M, IEB_BIT_I2C1_S};
    impl = ~(16'h1 << IEB_BIT_UNUSED);
    resetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    src_req = 16'hffff;
    void'($urandom(32'haf95));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // everything masked out of reset
    gate_chk(16'hffff, 16'h0);
    axi_rd(IEB_OFS_ENABLE, rd, rsp);
    chk(rd, 32'h0, "enable after reset");
    $display("test reset done");
    // one enable at a time, its source on then off
    foreach (bits[i]) begin
      b = 16'h1 << bits[i];
      axi_wr(IEB_OFS_ENABLE, {16'h0, b}, 4'h3, rsp);
      v = 16'($urandom) | b;
      gate_chk(v, b);
      gate_chk(v & ~b, b);
    end
    $display("test single bits done");
    // unimplemented bit stays zero
    axi_wr(IEB_OFS_ENABLE, 32'hffffffff, 4'hf, rsp);
    chk(32'(rsp), 32'(IEB_RESP_OKAY), "write response");
    axi_rd(IEB_OFS_ENABLE, rd, rsp);
    chk(rd, {16'h0, impl}, "all ones readback");
    gate_chk(16'hffff, impl);
    $display("test unused bit done");
    // random data, strobes and requests
    model = impl;
    repeat (40) begin
      v = 16'($urandom);
      st = 4'($urandom);
      axi_wr(IEB_OFS_ENABLE, {16'($urandom), v}, st, rsp);
      chk(32'(rsp), 32'(IEB_RESP_OKAY), "random write response");
      model = merge(model, v, st);
      axi_rd(IEB_OFS_ENABLE, rd, rsp);
      chk(rd, {16'h0, model}, "random readback");
      chk(32'(rsp), 32'(IEB_RESP_OKAY), "random read response");
      gate_chk(16'($urandom), model);
    end
    $display("test random done");
    // unmapped places refused, enable untouched
    axi_wr(4'h8, 32'h0, 4'hf, rsp);
    chk(32'(rsp), 32'(IEB_RESP_SLVERR), "unmapped write");
    axi_rd(4'hc, rd, rsp);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(rsp), 32'(IEB_RESP_SLVERR), "unmapped read");
    // raw request view shows the levels and refuses writes
    v = 16'($urandom);
    src_req <= v;
    axi_rd(IEB_OFS_PENDING, rd, rsp);
    chk(rd, {16'h0, v}, "request view data");
    chk(32'(rsp), 32'(IEB_RESP_OKAY), "request view response");
    axi_wr(IEB_OFS_PENDING, 32'hffffffff, 4'hf, rsp);
    chk(32'(rsp), 32'(IEB_RESP_SLVERR), "request view write");
    axi_rd(IEB_OFS_ENABLE, rd, rsp);
    chk(rd, {16'h0, model}, "after unmapped");
    $display("test unmapped done");
    // reset in mid-run clears the enables again
    resetn <= 1'b0;
    src_req <= 16'hffff;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    gate_chk(16'hffff, 16'h0);
    axi_rd(IEB_OFS_ENABLE, rd, rsp);
    chk(rd, 32'h0, "enable after second reset");
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
